// ==== verilog/flsc_top.sv ====
// Summary of operation
// - Write-unlock opcode framed by chip select sets the write latch flag.
// - Input sampled on rising SCK; status shifted out MSB first on falling SCK.
// - Volatile-unlock leaves the latch alone; it only enables a status write sent as the next command.
// - Write-lock opcode framed by chip select clears the write latch flag.
// - Latch clears at reset and when a timed status write or other operation completes.
// - Read-status opcodes return register one, two or three as eight bits.
// - Read-status commands work at any time, even while busy.
// - Selected register repeats on every byte while chip select stays low.
// - Ready-watch drives busy onto serial output continuously, ignoring SCK and input.
// - In ready-watch the output may fall to zero but never rises.
// - Chip select high ends ready-watch and releases the serial output.
// - Combined write: first byte to register one, optional second to register two.
// - Single-register writes take one byte for register two or three; extras ignored.
// - Only the listed protection, lock, quad and pause bits are writable.
// - One-time lock bits stay at one once set.
// - A status write needs a prior write-unlock or volatile-unlock.
// - Suspend, write latch and busy bits are never changed by written data.
// - Chip select must rise at 8 or 16 data bits for the combined write, or at any nonzero whole byte count for the others; otherwise the write is dropped.
// - Rising chip select starts a timed write unless volatile-unlocked; busy meanwhile, latch cleared at end.
// - Protect range field selects the read-only part of the array.
// - Lock bit zero locks status writes only while the write guard pin is low; lock bit one locks them on its own.
// - Hardware-protected mode refuses every status write command.
`timescale 1ns/1ps
module flsc_top
   import flsc_pkg::*;
#(
   parameter int STATUS_WRITE_CYC = STATUS_WRITE_CYCLES
) (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_b,
   input  wire logic       i_cs_n,
   input  wire logic       i_sck,
   input  wire logic       i_si,
   input  wire logic       i_wp_n,
   input  wire logic       i_array_busy,
   input  wire logic       i_op_done,
   input  wire logic       i_suspend,
   output logic            o_so,
   output logic            o_so_oe,
   output logic            o_busy,
   output logic            o_write_latch,
   output logic [4:0]      o_protect_range,
   output logic            o_protect_invert,
   output logic [2:0]      o_otp_lock,
   output logic            o_quad_io_enable,
   output logic            o_pause_reset_sel,
   output logic            o_status_locked
);
   logic        cs_n_s, sck_s, si_s, wp_n_s;
   logic        cs_d_q, sck_d_q;
   flsc_state_t st_q, st_d, op_next;
   logic [2:0]  bitcnt_q;
   logic [7:0]  sh_q, op_q, data0_q, data1_q;
   logic [1:0]  nbyte_q;
   logic        wel_q, vol_q, wr_vol_q, busy_q, lock_q;
   logic        so_q, so_oe_q;
   logic [4:0]  bp_q;
   logic [2:0]  lb_q;
   logic        status_lock_bit0_q, status_lock_bit1_q, qe_q, cmp_q, prs_q;
   logic [7:0]  sr1, sr2, sr3;
   logic        tmr_busy, tmr_done;
   logic        wr_nv_start;

   // Serial pins and the write guard cross into the clock domain before anything looks at them
   flsc_sync #(.RST_VAL(RST_CS_N)) u_sync_cs  (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
                                               .i_d(i_cs_n), .o_q(cs_n_s));
   flsc_sync #(.RST_VAL(1'b0))     u_sync_sck (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
                                               .i_d(i_sck), .o_q(sck_s));
   flsc_sync #(.RST_VAL(1'b0))     u_sync_si  (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
                                               .i_d(i_si), .o_q(si_s));
   flsc_sync #(.RST_VAL(1'b1))     u_sync_wp  (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
                                               .i_d(i_wp_n), .o_q(wp_n_s));

   flsc_wtimer #(.CYCLES(STATUS_WRITE_CYC)) u_wtimer (
      .i_mclk  (i_mclk),
      .i_rst_b (i_rst_b),
      .i_start (wr_nv_start),
      .o_busy  (tmr_busy),
      .o_done  (tmr_done)
   );

   // Link edges; SCK edges count only inside a frame
   wire       cs_fall   = ~cs_n_s & cs_d_q;
   wire       cs_rise   = cs_n_s & ~cs_d_q;
   wire       sck_rise  = sck_s & ~sck_d_q & ~cs_n_s;
   wire       sck_fall  = ~sck_s & sck_d_q & ~cs_n_s;
   wire       byte_done = sck_rise & (bitcnt_q == 3'h7);
   wire [7:0] opc_full  = {sh_q[6:0], si_s};

   // Opcode decode
   wire is_rd     = (opc_full == OP_READ_SR1) | (opc_full == OP_READ_SR2) |
                    (opc_full == OP_READ_SR3);
   wire is_watch  = (opc_full == OP_READY_WATCH);
   wire is_simple = (opc_full == OP_WRITE_UNLOCK) | (opc_full == OP_WRITE_LOCK) |
                    (opc_full == OP_VOL_UNLOCK);
   wire is_wr     = (opc_full == OP_WRITE_SR) | (opc_full == OP_WRITE_SR2) |
                    (opc_full == OP_WRITE_SR3);
   wire wr_permit = (wel_q | vol_q) & ~lock_q & ~busy_q;

   assign op_next = is_rd ? ST_READ :
                    is_watch ? ST_WATCH :
                    (is_simple & ~busy_q) ? ST_SIMPLE :
                    (is_wr & wr_permit) ? ST_WDATA : ST_IGNORE;

   always_comb begin
      st_d = st_q;
      if (cs_n_s) begin
         st_d = ST_IDLE;
      end else if (cs_fall) begin
         st_d = ST_OPC;
      end else begin
         case (st_q)
            ST_OPC:    if (byte_done) st_d = op_next;
            ST_SIMPLE: if (sck_rise) st_d = ST_IGNORE;
            default:   st_d = st_q;
         endcase
      end
   end

   // Chip-select-rise execution; single-byte commands must end on the opcode boundary
   wire simple_ok   = cs_rise & (st_q == ST_SIMPLE) & (bitcnt_q == 3'h0);
   wire exec_write_unlock_cmd   = simple_ok & (op_q == OP_WRITE_UNLOCK);
   wire exec_wrdi   = simple_ok & (op_q == OP_WRITE_LOCK);
   wire exec_vol    = simple_ok & (op_q == OP_VOL_UNLOCK);
   wire wr_boundary = cs_rise & (st_q == ST_WDATA) & (bitcnt_q == 3'h0) &
                      (nbyte_q != 2'h0) &
                      ((op_q != OP_WRITE_SR) | (nbyte_q != 2'h3));
   wire wr_bad      = cs_rise & (st_q == ST_WDATA) & ~wr_boundary;
   assign wr_nv_start = wr_boundary & ~wr_vol_q;
   wire wr_sr1      = wr_boundary & (op_q == OP_WRITE_SR);
   wire wr_sr2      = wr_boundary & (((op_q == OP_WRITE_SR) & (nbyte_q == 2'h2)) |
                                     (op_q == OP_WRITE_SR2));
   wire wr_sr3      = wr_boundary & (op_q == OP_WRITE_SR3);
   wire [7:0] sr2_data = (op_q == OP_WRITE_SR) ? data1_q : data0_q;
   wire wel_clr     = exec_wrdi | tmr_done | i_op_done;

   // Status images; unlisted bits read zero
   always_comb begin
      sr1 = 8'h00;
      sr1[SR1_BUSY_BIT]         = busy_q;
      sr1[SR1_WEL_BIT]          = wel_q;
      sr1[SR1_BP_LSB +: 5]      = bp_q;
      sr1[SR1_STATUS_LOCK_BIT0_BIT]         = status_lock_bit0_q;
      sr2 = 8'h00;
      sr2[SR2_STATUS_LOCK_BIT1_BIT]         = status_lock_bit1_q;
      sr2[SR2_QE_BIT]           = qe_q;
      sr2[SR2_LB_LSB +: 3]      = lb_q;
      sr2[SR2_CMP_BIT]          = cmp_q;
      sr2[SR2_SUS_BIT]          = i_suspend;
      sr3 = 8'h00;
      sr3[SR3_PRS_BIT]          = prs_q;
   end

   wire [7:0] sr_sel = (op_q == OP_READ_SR2) ? sr2 :
                       (op_q == OP_READ_SR3) ? sr3 : sr1;
   // Live bit each falling edge, so a repeated byte tracks a finishing cycle
   wire       rd_bit = sr_sel[~bitcnt_q];
   wire       oe_d   = ~cs_n_s & ((st_d == ST_READ) | (st_d == ST_WATCH));
   wire       watch_entry = (st_q == ST_OPC) & (st_d == ST_WATCH);

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         cs_d_q   <= RST_CS_N;
         sck_d_q  <= 1'b0;
         st_q     <= ST_IDLE;
         bitcnt_q <= 3'h0;
         sh_q     <= 8'h00;
         op_q     <= 8'h00;
         nbyte_q  <= 2'h0;
         data0_q  <= 8'h00;
         data1_q  <= 8'h00;
      end else begin
         cs_d_q  <= cs_n_s;
         sck_d_q <= sck_s;
         st_q    <= st_d;
         if (cs_fall) begin
            bitcnt_q <= 3'h0;
            nbyte_q  <= 2'h0;
         end else if (sck_rise) begin
            bitcnt_q <= bitcnt_q + 3'h1;
            sh_q     <= opc_full;
         end
         if (byte_done && st_q == ST_OPC) begin
            op_q <= opc_full;
         end
         if (byte_done && st_q == ST_WDATA) begin
            if (nbyte_q == 2'h0) begin
               data0_q <= opc_full;
            end
            if (nbyte_q == 2'h1) begin
               data1_q <= opc_full;
            end
            if (nbyte_q != 2'h3) begin
               nbyte_q <= nbyte_q + 2'h1;
            end
         end
      end
   end

   // Write latch and volatile-unlock token
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         wel_q    <= RST_BIT;
         vol_q    <= RST_BIT;
         wr_vol_q <= RST_BIT;
         busy_q   <= RST_BIT;
         lock_q   <= RST_BIT;
      end else begin
         // Set wins if a completion lands in the same cycle
         if (exec_write_unlock_cmd) begin
            wel_q <= 1'b1;
         end else if (wel_clr) begin
            wel_q <= 1'b0;
         end
         if (byte_done && st_q == ST_OPC) begin
            wr_vol_q <= vol_q;
            vol_q    <= 1'b0;
         end else if (exec_vol) begin
            vol_q <= 1'b1;
         end
         busy_q <= tmr_busy | i_array_busy;
         lock_q <= status_lock_bit1_q | (status_lock_bit0_q & ~wp_n_s);
      end
   end

   // Writable fields; busy, latch and suspend are never taken from data
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         bp_q   <= RST_BP;
         status_lock_bit0_q <= RST_BIT;
         status_lock_bit1_q <= RST_BIT;
         qe_q   <= RST_BIT;
         cmp_q  <= RST_BIT;
         lb_q   <= RST_LB;
         prs_q  <= RST_BIT;
      end else begin
         if (wr_sr1) begin
            bp_q   <= data0_q[SR1_BP_LSB +: 5];
            status_lock_bit0_q <= data0_q[SR1_STATUS_LOCK_BIT0_BIT];
         end
         if (wr_sr2) begin
            status_lock_bit1_q <= sr2_data[SR2_STATUS_LOCK_BIT1_BIT];
            qe_q   <= sr2_data[SR2_QE_BIT];
            cmp_q  <= sr2_data[SR2_CMP_BIT];
            lb_q   <= lb_q | sr2_data[SR2_LB_LSB +: 3];
         end
         if (wr_sr3) begin
            prs_q <= data0_q[SR3_PRS_BIT];
         end
      end
   end

   // Serial output
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         so_q    <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         so_oe_q <= oe_d;
         if (watch_entry) begin
            so_q <= busy_q;
         end else if (st_q == ST_WATCH) begin
            so_q <= so_q & busy_q;
         end else if (st_q == ST_READ && sck_fall) begin
            so_q <= rd_bit;
         end
      end
   end

   assign o_so              = so_q;
   assign o_so_oe           = so_oe_q;
   assign o_busy            = busy_q;
   assign o_write_latch     = wel_q;
   assign o_protect_range   = bp_q;
   assign o_protect_invert  = cmp_q;
   assign o_otp_lock        = lb_q;
   assign o_quad_io_enable  = qe_q;
   assign o_pause_reset_sel = prs_q;
   assign o_status_locked   = lock_q;

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   sequence s_watch_low;
      (st_q == ST_WATCH) && !so_q ##1 (st_q == ST_WATCH);
   endsequence
   sequence s_wr_cycle;
      ##2 busy_q;
   endsequence

   property p_write_unlock_cmd_sets;
      exec_write_unlock_cmd |=> wel_q;
   endproperty
   a_write_unlock_cmd_sets: assert property (p_write_unlock_cmd_sets)
      else $error("write latch not set after unlock");

   property p_vol_no_wel;
      exec_vol && !wel_q && !i_op_done |=> !wel_q && vol_q;
   endproperty
   a_vol_no_wel: assert property (p_vol_no_wel)
      else $error("volatile unlock changed latch or lost token");

   property p_wrdi_clears;
      exec_wrdi |=> !wel_q;
   endproperty
   a_wrdi_clears: assert property (p_wrdi_clears)
      else $error("write latch not cleared by lock opcode");

   property p_read_bit;
      (st_q == ST_READ) && sck_fall |=> so_q == $past(rd_bit);
   endproperty
   a_read_bit: assert property (p_read_bit)
      else $error("status bit not shifted out");

   property p_watch_drive;
      (st_q == ST_WATCH) ##1 (st_q == ST_WATCH) |-> so_oe_q;
   endproperty
   a_watch_drive: assert property (p_watch_drive)
      else $error("ready watch not driving output");

   property p_watch_no_rise;
      s_watch_low |-> !so_q;
   endproperty
   a_watch_no_rise: assert property (p_watch_no_rise)
      else $error("ready watch output rose");

   property p_release;
      cs_rise |=> !so_oe_q;
   endproperty
   a_release: assert property (p_release)
      else $error("output not released at deselect");

   property p_otp_sticky;
      (lb_q & $past(lb_q)) == $past(lb_q);
   endproperty
   a_otp_sticky: assert property (p_otp_sticky)
      else $error("one-time lock bit cleared");

   property p_bad_boundary;
      wr_bad |=> $stable(bp_q) && $stable(qe_q) && $stable(prs_q) ##1 !tmr_busy;
   endproperty
   a_bad_boundary: assert property (p_bad_boundary)
      else $error("misframed status write executed");

   property p_write_busy;
      wr_nv_start |-> s_wr_cycle;
   endproperty
   a_write_busy: assert property (p_write_busy)
      else $error("busy not raised by status write");

   property p_done_clears;
      tmr_done && !exec_write_unlock_cmd |=> !wel_q;
   endproperty
   a_done_clears: assert property (p_done_clears)
      else $error("write latch not cleared at cycle end");

   property p_locked_refuse;
      (st_q == ST_OPC) && byte_done && is_wr && lock_q |=> st_q == ST_IGNORE;
   endproperty
   a_locked_refuse: assert property (p_locked_refuse)
      else $error("status write accepted while protected");

endmodule

// ==== verilog/flsc_pkg.sv ====
package flsc_pkg;

   // Timing
   localparam int MCLK_PERIOD_NS       = 40;
   // Plain default; no figure is fixed for the self-timed status write
   localparam int STATUS_WRITE_TIME_NS = 5000000;
   localparam int STATUS_WRITE_CYCLES  = (STATUS_WRITE_TIME_NS / MCLK_PERIOD_NS < 1) ? 1 :
                                         STATUS_WRITE_TIME_NS / MCLK_PERIOD_NS;

   // Opcodes
   localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
   localparam logic [7:0] OP_VOL_UNLOCK   = 8'h50;
   localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
   localparam logic [7:0] OP_READ_SR1     = 8'h05;
   localparam logic [7:0] OP_READ_SR2     = 8'h35;
   localparam logic [7:0] OP_READ_SR3     = 8'h15;
   localparam logic [7:0] OP_WRITE_SR     = 8'h01;
   localparam logic [7:0] OP_WRITE_SR2    = 8'h31;
   localparam logic [7:0] OP_WRITE_SR3    = 8'h11;
   localparam logic [7:0] OP_READY_WATCH  = 8'h25;

   // Status register one field positions
   localparam int SR1_BUSY_BIT = 0;
   localparam int SR1_WEL_BIT  = 1;
   localparam int SR1_BP_LSB   = 2;
   localparam int SR1_STATUS_LOCK_BIT0_BIT = 7;
   // Status register two field positions
   localparam int SR2_STATUS_LOCK_BIT1_BIT = 0;
   localparam int SR2_QE_BIT   = 1;
   localparam int SR2_LB_LSB   = 3;
   localparam int SR2_CMP_BIT  = 6;
   localparam int SR2_SUS_BIT  = 7;
   // Status register three field position
   localparam int SR3_PRS_BIT  = 7;

   // Reset values
   localparam logic [4:0] RST_BP   = 5'h00;
   localparam logic [2:0] RST_LB   = 3'h0;
   localparam logic       RST_BIT  = 1'b0;
   localparam logic       RST_CS_N = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPC,
      ST_READ,
      ST_WATCH,
      ST_WDATA,
      ST_SIMPLE,
      ST_IGNORE
   } flsc_state_t;

endpackage

// ==== verilog/flsc_sync.sv ====
`timescale 1ns/1ps
module flsc_sync
   import flsc_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         meta_q <= RST_VAL;
         o_q    <= RST_VAL;
      end else begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end
endmodule

// ==== verilog/flsc_wtimer.sv ====
`timescale 1ns/1ps
module flsc_wtimer
   import flsc_pkg::*;
#(
   parameter int CYCLES = STATUS_WRITE_CYCLES
) (
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   input  wire logic i_start,
   output logic      o_busy,
   output logic      o_done
);
   logic [31:0] cnt_q;

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         cnt_q  <= 32'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            o_busy <= 1'b1;
            cnt_q  <= 32'h0;
         end else if (o_busy) begin
            if (cnt_q == 32'(CYCLES - 1)) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 32'h1;
            end
         end
      end
   end
endmodule

// ==== sim/flsc_host_model.sv ====
`timescale 1ns/1ps
module flsc_host_model (
   input  wire logic i_mclk,
   input  wire logic i_so,
   input  wire logic i_so_oe,
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_si
);
   // SCK idles low between frames; four master clocks per half period
   localparam int HALF = 4;
   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_si   = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic begin_frame();
      o_cs_n <= 1'b0;
      tick(HALF);
   endtask
   // Data changes while SCK is low and is read late in the high phase
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_sck <= 1'b0;
         o_si  <= tx[i];
         tick(HALF);
         o_sck <= 1'b1;
         tick(HALF);
         rx[i] = i_so_oe ? i_so : 1'bx;
      end
   endtask
   // Select rises only once SCK is back low at a byte boundary
   task automatic end_frame();
      o_sck <= 1'b0;
      tick(HALF);
      o_cs_n <= 1'b1;
      o_si   <= ~o_si;
      tick(2 * HALF);
   endtask
endmodule

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import flsc_pkg::*;
   logic       mclk, rst_b, cs_n, sck, si, wp_n, abusy, op_done, susp;
   logic       so, so_oe, busy, write_latch_flag, pinv, qe, psel, locked;
   logic [4:0] prange;
   logic [2:0] otp;
   int         err_total = 0;
   int         checks = 0;
   int         cyc = 0;
   logic [7:0] cmd_r;
   flsc_top #(.STATUS_WRITE_CYC(400)) uut (
      .i_mclk(mclk), .i_rst_b(rst_b), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
      .i_wp_n(wp_n), .i_array_busy(abusy), .i_op_done(op_done), .i_suspend(susp),
      .o_so(so), .o_so_oe(so_oe), .o_busy(busy), .o_write_latch(write_latch_flag),
      .o_protect_range(prange), .o_protect_invert(pinv), .o_otp_lock(otp),
      .o_quad_io_enable(qe), .o_pause_reset_sel(psel), .o_status_locked(locked));
   flsc_host_model host (
      .i_mclk(mclk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Ceiling well above the roughly 6400 cycles the sequence needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      logic [7:0] r;
      host.begin_frame();
      host.xfer(op, r);
      host.end_frame();
   endtask
   task automatic wr(input logic [7:0] op, b1, b2, input int n);
      logic [7:0] r;
      host.begin_frame();
      host.xfer(op, r);
      host.xfer(b1, r);
      if (n > 1) host.xfer(b2, r);
      if (n > 2) host.xfer(8'h00, r);
      host.end_frame();
   endtask
   // Two bytes are read so that the repeat of the register is seen too
   task automatic rd(input logic [7:0] op, exp);
      logic [7:0] r1, r2;
      host.begin_frame();
      host.xfer(op, r1);
      host.xfer(8'h00, r1);
      host.xfer(8'h00, r2);
      host.end_frame();
      chk("status byte", r1, exp);
      chk("status repeat", r2, exp);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 1000) begin
         @(posedge mclk);
         n++;
      end
      chk("write cycle ends", 8'(n < 1000), 8'h01);
   endtask
   task automatic tend(input int n);
      $display("test %0d done", n);
   endtask
   initial begin
      rst_b = 1'b0;
      wp_n = 1'b1;
      abusy = 1'b0;
      op_done = 1'b0;
      susp = 1'b0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(OP_READ_SR1, 8'h00);
      rd(OP_READ_SR2, 8'h00);
      rd(OP_READ_SR3, 8'h00);
      tend(1);
      cmd(OP_WRITE_UNLOCK);
      chk("latch set", 8'(write_latch_flag), 8'h01);
      rd(OP_READ_SR1, 8'h02);
      cmd(OP_WRITE_LOCK);
      chk("latch clear", 8'(write_latch_flag), 8'h00);
      wr(OP_WRITE_SR, 8'hff, 8'h00, 1);
      chk("no latch write", 8'(prange), 8'h00);
      tend(2);
      cmd(OP_WRITE_UNLOCK);
      wr(OP_WRITE_SR, 8'hff, 8'h00, 1);
      rd(OP_READ_SR1, 8'hff);
      wait_idle();
      chk("latch after cycle", 8'(write_latch_flag), 8'h00);
      rd(OP_READ_SR1, 8'hfc);
      chk("protect range", 8'(prange), 8'h1f);
      tend(3);
      wp_n <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("locked", 8'(locked), 8'h01);
      cmd(OP_WRITE_UNLOCK);
      wr(OP_WRITE_SR, 8'h00, 8'h00, 1);
      rd(OP_READ_SR1, 8'hfe);
      cmd(OP_WRITE_LOCK);
      wp_n <= 1'b1;
      tend(4);
      cmd(OP_WRITE_UNLOCK);
      wr(OP_WRITE_SR, 8'h00, 8'h7a, 2);
      wait_idle();
      rd(OP_READ_SR1, 8'h00);
      rd(OP_READ_SR2, 8'h7a);
      chk("quad enable set", 8'(qe), 8'h01);
      chk("protect invert set", 8'(pinv), 8'h01);
      cmd(OP_WRITE_UNLOCK);
      wr(OP_WRITE_SR2, 8'h00, 8'hff, 2);
      wait_idle();
      rd(OP_READ_SR2, 8'h38);
      chk("otp sticky", 8'(otp), 8'h07);
      chk("quad enable cleared", 8'(qe), 8'h00);
      chk("protect invert cleared", 8'(pinv), 8'h00);
      cmd(OP_WRITE_UNLOCK);
      wr(OP_WRITE_SR3, 8'hff, 8'h00, 1);
      wait_idle();
      rd(OP_READ_SR3, 8'h80);
      chk("pause select", 8'(psel), 8'h01);
      tend(5);
      cmd(OP_WRITE_UNLOCK);
      wr(OP_WRITE_SR, 8'hff, 8'hff, 3);
      chk("misframed dropped", 8'(prange), 8'h00);
      chk("misframed no cycle", 8'(busy), 8'h00);
      cmd(OP_WRITE_LOCK);
      cmd(OP_VOL_UNLOCK);
      chk("volatile no latch", 8'(write_latch_flag), 8'h00);
      wr(OP_WRITE_SR, 8'h7c, 8'h00, 1);
      chk("volatile applied", 8'(prange), 8'h1f);
      chk("volatile no cycle", 8'({busy, write_latch_flag}), 8'h00);
      tend(6);
      abusy <= 1'b1;
      repeat (2) @(posedge mclk);
      host.begin_frame();
      host.xfer(OP_READY_WATCH, cmd_r);
      host.tick(16);
      chk("watch busy", 8'({so_oe, so}), 8'h03);
      abusy <= 1'b0;
      host.tick(8);
      chk("watch ready", 8'({so_oe, so}), 8'h02);
      abusy <= 1'b1;
      host.tick(8);
      chk("watch no rise", 8'({so_oe, so}), 8'h02);
      host.end_frame();
      chk("watch released", 8'(so_oe), 8'h00);
      abusy <= 1'b0;
      tend(7);
      cmd(OP_WRITE_UNLOCK);
      op_done <= 1'b1;
      @(posedge mclk);
      op_done <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("done clears latch", 8'(write_latch_flag), 8'h00);
      susp <= 1'b1;
      rd(OP_READ_SR2, 8'hb8);
      tend(8);
      print_verdict();
   end
endmodule
